// *** uhm_pkg.sv ***
package uhm_pkg;
   // Register select codes on the three address lines
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   localparam logic [2:0] ADDR_EFR = 3'h2;
   localparam logic [2:0] ADDR_SCR = 3'h7;
   // Modem control bit positions
   localparam int MCR_DTR_BIT = 0;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_OP1_BIT = 2;
   localparam int MCR_OP2_BIT = 3;
   // Modem status bit positions
   localparam int MSR_CTS_BIT = 4;
   localparam int MSR_DSR_BIT = 5;
   localparam int MSR_CD_BIT = 7;
   // Enhanced feature bit: automatic clear-to-send flow control
   localparam int EFR_AUTO_CTS_BIT = 7;
   // Reset values
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET = 8'h00;
   localparam logic [7:0] SCR_RESET = 8'h00;
   // Baud divisor reset value, FIFO sizing, transmit and receive oversampling, data bit count
   localparam logic [15:0] DIVISOR_RESET = 16'h0001;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
   localparam logic [3:0] DATA_BITS_LAST = 4'h7;

   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic cd_n;
   } uhm_modem_in_t;

   typedef struct packed {
      logic dtr_n;
      logic rts_n;
      logic op1_n;
      logic op2_n;
   } uhm_modem_out_t;
endpackage

// *** uhm_fifo.sv ***
`timescale 1ns/10ps
module uhm_fifo (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [7:0] push_data,
   input wire logic pop,
   output logic [7:0] head,
   output logic empty,
   output logic full
);
   logic [7:0] mem [0:uhm_pkg::FIFO_DEPTH-1];
   logic [uhm_pkg::FIFO_AW-1:0] wr_reg;
   logic [uhm_pkg::FIFO_AW-1:0] rd_reg;
   logic [4:0] cnt_reg;
   wire do_push = push && !full;
   wire do_pop = pop && !empty;

   assign empty = (cnt_reg == 5'h00);
   assign full = (cnt_reg == uhm_pkg::FIFO_FULL_COUNT);
   assign head = mem[rd_reg];

   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_reg] <= push_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_reg <= 4'h0;
         rd_reg <= 4'h0;
         cnt_reg <= 5'h00;
      end else begin
         if (do_push) begin
            wr_reg <= wr_reg + 4'h1;
         end
         if (do_pop) begin
            rd_reg <= rd_reg + 4'h1;
         end
         if (do_push && !do_pop) begin
            cnt_reg <= cnt_reg + 5'h01;
         end else if (do_pop && !do_push) begin
            cnt_reg <= cnt_reg - 5'h01;
         end
      end
   end
endmodule

// *** uhm_baud.sv ***
`timescale 1ns/10ps
module uhm_baud (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [15:0] divisor,
   output logic tick,
   output logic clk16_n
);
   logic [15:0] cnt_reg;
   logic [15:0] half;
   wire wrap = (cnt_reg >= divisor - 16'h0001);

   assign half = {1'b0, divisor[15:1]};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         tick <= 1'b0;
         clk16_n <= 1'b1;
      end else begin
         cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
         tick <= wrap;
         clk16_n <= !(cnt_reg < half || divisor == 16'h0001);
      end
   end
endmodule

// *** uhm_top.sv ***
`timescale 1ns/10ps
// Operation
// R1: Low read strobe drives addressed register onto data bus.
// R2: Low write strobe loads data bus into addressed register.
// R3: Receive-ready low while receive data waits.
// R4: Transmit-ready low while a transmit slot is free, high when full.
// R5: Baud output is sixteen times the programmed rate. Code holds it low at divisor 1 and high at divisor 0.
// R6: Receiver samples on its own 16X receive clock input.
// R7: Drive-disable low during any host read.
// R8: First user output follows modem control bit 2.
// R9: Second user output follows modem control bit 3.
// R10: Reset clears registers and outputs; serial lines idle during reset.
// R11: Clear-to-send level readable at modem status bit 4.
// R12: Clear-to-send gates transmit only with auto flow control bit 7.
// R13: Data-set-ready never affects transmit or receive.
// R14: Terminal-ready low when modem control bit 0 is one.
// R15: Low carrier-detect means a carrier is present.
// R16: Host selects with chip selects a, b high and c low.
// R17: Address strobe falling edge latches selects; held low is transparent. Code is transparent only until the first fall after reset.
// R18: Either read strobe polarity starts a read.
// R19: Request-to-send low when modem control bit 1 is one.
// R20: Data bus not driven unless selected and reading.
module uhm_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chip_select_a,
   input wire logic chip_select_b,
   input wire logic chip_select_c_n,
   input wire logic address_latch_strobe_n,
   input wire logic [2:0] addr,
   input wire logic host_read_strobe_n,
   input wire logic host_read_strobe_hi,
   input wire logic host_write_strobe_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic drive_disable_n,
   output logic receive_ready_n,
   output logic transmit_ready_n,
   output logic baud_out_n,
   input wire logic receive_clock_16x,
   input wire logic serial_in,
   output logic serial_out,
   input wire uhm_pkg::uhm_modem_in_t modem_in,
   output uhm_pkg::uhm_modem_out_t modem_out
);
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uhm_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhm_rx_state_t;

   logic as_seen_reg;
   logic [7:0] modem_control_reg;
   logic [7:0] enhanced_feature_reg;
   logic [7:0] scratch_reg;
   logic [15:0] divisor_reg;
   logic [2:0] addr_hold_reg;
   logic sel_hold_reg;
   logic as_prev_reg;
   logic rd_prev_reg;
   logic wr_prev_reg;
   logic rclk_prev_reg;
   uhm_tx_state_t tx_state_reg;
   uhm_rx_state_t rx_state_reg;
   logic [3:0] tx_phase_reg;
   logic [2:0] tx_bit_reg;
   logic [7:0] tx_shift_reg;
   logic [3:0] rx_phase_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic rx_push_reg;

   // Address and select capture
   wire sel_now = chip_select_a && chip_select_b && !chip_select_c_n; // R16
   wire as_fall = as_prev_reg && !address_latch_strobe_n;
   // Pins pass straight through until a strobe fall; after it the held copy rules
   wire transparent = !as_seen_reg || as_fall;
   wire selected = transparent ? sel_now : sel_hold_reg; // R17
   wire [2:0] reg_sel = transparent ? addr : addr_hold_reg; // R17
   wire read_act = selected && (!host_read_strobe_n || host_read_strobe_hi); // R18
   wire write_act = selected && !host_write_strobe_n;
   wire read_end = rd_prev_reg && !read_act;
   wire write_start = write_act && !wr_prev_reg; // R2

   // Transmit and receive FIFOs
   logic [7:0] txf_head;
   logic txf_empty;
   logic txf_full;
   logic [7:0] rxf_head;
   logic rxf_empty;
   logic rxf_full;
   logic baud_tick;
   logic baud_clk_n;

   wire tx_push = write_start && reg_sel == uhm_pkg::ADDR_DATA;
   wire rx_pop = read_end && reg_sel == uhm_pkg::ADDR_DATA;
   wire cts_ok = !enhanced_feature_reg[uhm_pkg::EFR_AUTO_CTS_BIT] || !modem_in.cts_n; // R12
   wire tx_load = tx_state_reg == TX_IDLE && !txf_empty && cts_ok && baud_tick;
   wire rx_tick = receive_clock_16x && !rclk_prev_reg; // R6

   uhm_fifo u_txf (
      .clock(clock),
      .rst_n(rst_n),
      .push(tx_push),
      .push_data(data_in),
      .pop(tx_load),
      .head(txf_head),
      .empty(txf_empty),
      .full(txf_full)
   );

   uhm_fifo u_rxf (
      .clock(clock),
      .rst_n(rst_n),
      .push(rx_push_reg),
      .push_data(rx_shift_reg),
      .pop(rx_pop),
      .head(rxf_head),
      .empty(rxf_empty),
      .full(rxf_full)
   );

   uhm_baud u_baud (
      .clock(clock),
      .rst_n(rst_n),
      .divisor(divisor_reg),
      .tick(baud_tick),
      .clk16_n(baud_clk_n)
   );

   // Status view: modem lines shown asserted-high as software expects
   wire [7:0] msr_view = {!modem_in.cd_n, 1'b0, !modem_in.dsr_n, !modem_in.cts_n, 4'h0}; // R11 R15
   wire [7:0] read_mux = (reg_sel == uhm_pkg::ADDR_DATA) ? rxf_head :
                         (reg_sel == uhm_pkg::ADDR_MCR) ? modem_control_reg :
                         (reg_sel == uhm_pkg::ADDR_MSR) ? msr_view :
                         (reg_sel == uhm_pkg::ADDR_EFR) ? enhanced_feature_reg :
                         (reg_sel == uhm_pkg::ADDR_SCR) ? scratch_reg : 8'h00;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         as_prev_reg <= 1'b0;
         as_seen_reg <= 1'b0;
         sel_hold_reg <= 1'b0;
         addr_hold_reg <= 3'h0;
         rd_prev_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
         rclk_prev_reg <= 1'b0;
      end else begin
         as_prev_reg <= address_latch_strobe_n;
         if (as_fall) begin
            sel_hold_reg <= sel_now; // R17
            addr_hold_reg <= addr;
            as_seen_reg <= 1'b1;
         end
         rd_prev_reg <= read_act;
         wr_prev_reg <= write_act;
         rclk_prev_reg <= receive_clock_16x;
      end
   end

   // Host register writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         modem_control_reg <= uhm_pkg::MCR_RESET; // R10
         enhanced_feature_reg <= uhm_pkg::EFR_RESET;
         scratch_reg <= uhm_pkg::SCR_RESET;
         divisor_reg <= uhm_pkg::DIVISOR_RESET;
      end else if (write_start) begin
         case (reg_sel)
            uhm_pkg::ADDR_MCR: modem_control_reg <= data_in; // R2
            uhm_pkg::ADDR_EFR: enhanced_feature_reg <= data_in;
            uhm_pkg::ADDR_SCR: scratch_reg <= data_in;
            3'h1: divisor_reg[7:0] <= data_in;
            3'h3: divisor_reg[15:8] <= data_in;
            default: scratch_reg <= scratch_reg;
         endcase
      end
   end

   // Pin outputs, all registered
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         drive_disable_n <= 1'b1;
         receive_ready_n <= 1'b1;
         transmit_ready_n <= 1'b0;
         baud_out_n <= 1'b1;
         modem_out <= '{dtr_n: 1'b1, rts_n: 1'b1, op1_n: 1'b1, op2_n: 1'b1}; // R10
      end else begin
         data_out <= read_mux; // R1
         data_oe <= read_act; // R20
         drive_disable_n <= !read_act; // R7
         receive_ready_n <= rxf_empty; // R3
         transmit_ready_n <= txf_full || (tx_push && !tx_load && u_txf.cnt_reg == 5'h0F); // R4
         baud_out_n <= baud_clk_n; // R5
         modem_out.dtr_n <= !modem_control_reg[uhm_pkg::MCR_DTR_BIT]; // R14
         modem_out.rts_n <= !modem_control_reg[uhm_pkg::MCR_RTS_BIT]; // R19
         modem_out.op1_n <= !modem_control_reg[uhm_pkg::MCR_OP1_BIT]; // R8
         modem_out.op2_n <= !modem_control_reg[uhm_pkg::MCR_OP2_BIT]; // R9
      end
   end

   // Transmitter: 8N1 on the internal 16X tick; data-set-ready not used (R13)
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_state_reg <= TX_IDLE;
         tx_phase_reg <= 4'h0;
         tx_bit_reg <= 3'h0;
         tx_shift_reg <= 8'h00;
         serial_out <= 1'b1; // R10
      end else if (tx_load) begin
         tx_state_reg <= TX_START;
         tx_shift_reg <= txf_head;
         tx_phase_reg <= 4'h0;
         serial_out <= 1'b0;
      end else if (baud_tick) begin
         tx_phase_reg <= tx_phase_reg + 4'h1;
         if (tx_phase_reg == uhm_pkg::OVERSAMPLE_LAST) begin
            case (tx_state_reg)
               TX_START: begin
                  tx_state_reg <= TX_DATA;
                  tx_bit_reg <= 3'h0;
                  serial_out <= tx_shift_reg[0];
               end
               TX_DATA: begin
                  if (tx_bit_reg == uhm_pkg::DATA_BITS_LAST[2:0]) begin
                     tx_state_reg <= TX_STOP;
                     serial_out <= 1'b1;
                  end else begin
                     tx_bit_reg <= tx_bit_reg + 3'h1;
                     tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                     serial_out <= tx_shift_reg[1];
                  end
               end
               TX_STOP: tx_state_reg <= TX_IDLE;
               default: tx_state_reg <= TX_IDLE;
            endcase
         end
      end
   end

   // Receiver: sampled on edges of the external 16X receive clock
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_state_reg <= RX_IDLE; // R10
         rx_phase_reg <= 4'h0;
         rx_bit_reg <= 3'h0;
         rx_shift_reg <= 8'h00;
         rx_push_reg <= 1'b0;
      end else begin
         rx_push_reg <= 1'b0;
         if (rx_tick) begin // R6
            rx_phase_reg <= rx_phase_reg + 4'h1;
            case (rx_state_reg)
               RX_IDLE: begin
                  rx_phase_reg <= 4'h0;
                  if (!serial_in) begin
                     rx_state_reg <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_phase_reg == uhm_pkg::OVERSAMPLE_MID) begin
                     rx_phase_reg <= 4'h0;
                     rx_bit_reg <= 3'h0;
                     rx_state_reg <= serial_in ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_phase_reg == uhm_pkg::OVERSAMPLE_LAST) begin
                     rx_shift_reg <= {serial_in, rx_shift_reg[7:1]};
                     rx_bit_reg <= rx_bit_reg + 3'h1;
                     if (rx_bit_reg == uhm_pkg::DATA_BITS_LAST[2:0]) begin
                        rx_state_reg <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rx_phase_reg == uhm_pkg::OVERSAMPLE_LAST) begin
                     rx_push_reg <= serial_in && !rxf_full;
                     rx_state_reg <= RX_IDLE;
                  end
               end
               default: rx_state_reg <= RX_IDLE;
            endcase
         end
      end
   end

   AST_READ_DRIVES: assert property (@(posedge clock) disable iff (!rst_n) // R1
      read_act |=> data_oe && data_out == $past(read_mux))
      else $error("data not driven during read");
   AST_WRITE_MCR: assert property (@(posedge clock) disable iff (!rst_n) // R2
      write_start && reg_sel == uhm_pkg::ADDR_MCR |=> modem_control_reg == $past(data_in))
      else $error("modem control write lost");
   AST_RECEIVE_READY_N: assert property (@(posedge clock) disable iff (!rst_n) // R3
      !rxf_empty |=> !receive_ready_n)
      else $error("receive ready not low with data");
   AST_TRANSMIT_READY_N: assert property (@(posedge clock) disable iff (!rst_n) // R4
      txf_full |=> transmit_ready_n)
      else $error("transmit ready low while full");
   AST_DRIVE_DISABLE_N: assert property (@(posedge clock) disable iff (!rst_n) // R7
      read_act |=> !drive_disable_n)
      else $error("drive disable not low in read");
   AST_OUTS: assert property (@(posedge clock) disable iff (!rst_n) // R8 R9
      ##1 modem_out.op1_n == !$past(modem_control_reg[2]) &&
      modem_out.op2_n == !$past(modem_control_reg[3]))
      else $error("user outputs wrong");
   AST_DTR_RTS: assert property (@(posedge clock) disable iff (!rst_n) // R14 R19
      ##1 modem_out.dtr_n == !$past(modem_control_reg[0]) &&
      modem_out.rts_n == !$past(modem_control_reg[1]))
      else $error("terminal or send ready wrong");
   AST_CTS_GATE: assert property (@(posedge clock) disable iff (!rst_n) // R12
      enhanced_feature_reg[7] && modem_in.cts_n |-> !tx_load)
      else $error("sent while flow stopped");
   AST_RESET_IDLE: assert property (@(posedge clock) // R10
      !rst_n |=> serial_out && drive_disable_n && !data_oe)
      else $error("outputs not reset");
   AST_HIZ: assert property (@(posedge clock) disable iff (!rst_n) // R20
      !read_act |=> !data_oe)
      else $error("bus driven while idle");
   COV_READ: cover property (@(posedge clock) disable iff (!rst_n) read_act ##1 read_end);
   COV_TX: cover property (@(posedge clock) disable iff (!rst_n) tx_load);
   COV_RX: cover property (@(posedge clock) disable iff (!rst_n) rx_push_reg);
   COV_FULL: cover property (@(posedge clock) disable iff (!rst_n) txf_full);
endmodule

// *** uhm_far_model.sv ***
`timescale 1ns/10ps
// Board and modem seen from the device pins
module uhm_far_model (
   input wire logic clock,
   input wire logic cts_n_ctl,
   input wire logic dsr_n_ctl,
   input wire logic cd_n_ctl,
   input wire logic baud_out_n,
   input wire logic serial_out,
   output logic receive_clock_16x,
   output logic serial_in,
   output uhm_pkg::uhm_modem_in_t modem_in
);
   // Board strap: receiver runs from the internal baud generator
   assign receive_clock_16x = baud_out_n;
   // Serial loop so transmitted characters come back to the receiver
   assign serial_in = serial_out;
   // Modem handshake levels change only after a clock edge
   always_ff @(posedge clock) begin
      modem_in.cts_n <= cts_n_ctl;
      modem_in.dsr_n <= dsr_n_ctl;
      modem_in.cd_n <= cd_n_ctl;
   end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic chip_select_a = 1'b1;
   logic chip_select_b = 1'b1;
   logic chip_select_c_n = 1'b0;
   logic address_latch_strobe_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic host_read_strobe_n = 1'b1;
   logic host_read_strobe_hi = 1'b0;
   logic host_write_strobe_n = 1'b1;
   logic [7:0] data_in = 8'h00;
   logic [7:0] data_out;
   logic data_oe, drive_disable_n, receive_ready_n, transmit_ready_n;
   logic baud_out_n, receive_clock_16x, serial_in, serial_out;
   logic cts_n_ctl = 1'b1;
   logic dsr_n_ctl = 1'b1;
   logic cd_n_ctl = 1'b1;
   uhm_pkg::uhm_modem_in_t modem_in;
   uhm_pkg::uhm_modem_out_t modem_out;
   int errors = 0;
   int compares = 0;
   int cycles = 0;

   uhm_top dut (.clock(clock), .rst_n(rst_n), .chip_select_a(chip_select_a),
      .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
      .address_latch_strobe_n(address_latch_strobe_n), .addr(addr),
      .host_read_strobe_n(host_read_strobe_n), .host_read_strobe_hi(host_read_strobe_hi),
      .host_write_strobe_n(host_write_strobe_n), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .drive_disable_n(drive_disable_n),
      .receive_ready_n(receive_ready_n), .transmit_ready_n(transmit_ready_n),
      .baud_out_n(baud_out_n), .receive_clock_16x(receive_clock_16x),
      .serial_in(serial_in), .serial_out(serial_out), .modem_in(modem_in),
      .modem_out(modem_out));

   uhm_far_model far (.clock(clock), .cts_n_ctl(cts_n_ctl), .dsr_n_ctl(dsr_n_ctl),
      .cd_n_ctl(cd_n_ctl), .baud_out_n(baud_out_n), .serial_out(serial_out),
      .receive_clock_16x(receive_clock_16x), .serial_in(serial_in), .modem_in(modem_in));

   initial begin
      forever #20 clock = ~clock;
   end

   task automatic close_out();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         close_out();
      end
   end

   task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      data_in <= d;
      host_write_strobe_n <= 1'b0;
      @(posedge clock);
      host_write_strobe_n <= 1'b1;
      @(posedge clock);
   endtask

   task automatic host_rd(input logic [2:0] a, input logic hi, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clock);
      addr <= a;
      if (hi) begin
         host_read_strobe_hi <= 1'b1;
      end else begin
         host_read_strobe_n <= 1'b0;
      end
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (data_oe !== 1'b1 && n < 20);
      `CHK(data_oe, 1'b1)
      `CHK(drive_disable_n, 1'b0)
      q = data_out;
      @(posedge clock);
      host_read_strobe_hi <= 1'b0;
      host_read_strobe_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      `CHK(data_oe, 1'b0)
      `CHK(drive_disable_n, 1'b1)
   endtask

   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
      `CHK({data_oe, drive_disable_n, receive_ready_n, transmit_ready_n}, 4'h6)
      `CHK(serial_out, 1'b1)
      `CHK(modem_out, 4'hF)
      @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      $display("test reset done");
   endtask

   task automatic test_modem_control();
      uhm_pkg::uhm_modem_out_t e;
      logic [7:0] v;
      for (int i = 0; i < 5; i++) begin
         v = (i == 4) ? 8'h0F : (8'h01 << i);
         host_wr(uhm_pkg::ADDR_MCR, v);
         e.dtr_n = ~v[uhm_pkg::MCR_DTR_BIT];
         e.rts_n = ~v[uhm_pkg::MCR_RTS_BIT];
         e.op1_n = ~v[uhm_pkg::MCR_OP1_BIT];
         e.op2_n = ~v[uhm_pkg::MCR_OP2_BIT];
         #1;
         `CHK(modem_out, e)
      end
      $display("test modem control done");
   endtask

   task automatic test_scratch_select();
      logic [7:0] q;
      host_wr(uhm_pkg::ADDR_SCR, 8'hA5);
      host_rd(uhm_pkg::ADDR_SCR, 1'b0, q);
      `CHK(q, 8'hA5)
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         chip_select_a <= (i != 0);
         chip_select_b <= (i != 1);
         chip_select_c_n <= (i == 2);
         host_wr(uhm_pkg::ADDR_SCR, 8'h11);
         chip_select_a <= 1'b1;
         chip_select_b <= 1'b1;
         chip_select_c_n <= 1'b0;
         host_rd(uhm_pkg::ADDR_SCR, 1'b1, q);
         `CHK(q, 8'hA5)
      end
      $display("test scratch and select done");
   endtask

   task automatic test_address_latch();
      logic [7:0] q;
      @(posedge clock);
      address_latch_strobe_n <= 1'b1;
      addr <= uhm_pkg::ADDR_SCR;
      @(posedge clock);
      address_latch_strobe_n <= 1'b0;
      @(posedge clock);
      chip_select_c_n <= 1'b1;
      host_wr(uhm_pkg::ADDR_MCR, 8'h3C);
      #1;
      `CHK(modem_out, 4'hF)
      @(posedge clock);
      address_latch_strobe_n <= 1'b1;
      chip_select_c_n <= 1'b0;
      addr <= uhm_pkg::ADDR_SCR;
      @(posedge clock);
      address_latch_strobe_n <= 1'b0;
      host_rd(uhm_pkg::ADDR_SCR, 1'b0, q);
      `CHK(q, 8'h3C)
      $display("test address latch done");
   endtask

   task automatic test_modem_status();
      logic [7:0] q;
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         cts_n_ctl <= i[0];
         dsr_n_ctl <= i[1];
         cd_n_ctl <= i[2];
         repeat (4) @(posedge clock);
         host_rd(uhm_pkg::ADDR_MSR, i[0], q);
         `CHK(q[uhm_pkg::MSR_CTS_BIT], ~i[0])
         `CHK(q[uhm_pkg::MSR_DSR_BIT], ~i[1])
         `CHK(q[uhm_pkg::MSR_CD_BIT], ~i[2])
      end
      $display("test modem status done");
   endtask

   task automatic test_fifo_flow();
      logic [7:0] q;
      int n;
      host_wr(3'h1, 8'h04);
      host_wr(3'h3, 8'h00);
      @(posedge clock);
      cts_n_ctl <= 1'b1;
      host_wr(uhm_pkg::ADDR_EFR, 8'h80);
      for (int i = 0; i < 16; i++) begin
         #1;
         `CHK(transmit_ready_n, 1'b0)
         host_wr(uhm_pkg::ADDR_DATA, 8'h30 + i[7:0]);
      end
      repeat (2) @(posedge clock);
      #1;
      `CHK(transmit_ready_n, 1'b1)
      `CHK(receive_ready_n, 1'b1)
      @(posedge clock);
      cts_n_ctl <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         n = 0;
         while (receive_ready_n !== 1'b0 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
         end
         `CHK(receive_ready_n, 1'b0)
         host_rd(uhm_pkg::ADDR_DATA, 1'b0, q);
         `CHK(q, 8'h30 + i[7:0])
      end
      repeat (3) @(posedge clock);
      #1;
      `CHK(receive_ready_n, 1'b1)
      `CHK(transmit_ready_n, 1'b0)
      $display("test fifo and flow control done");
   endtask

   initial begin
      do_reset();
      test_address_latch();
      do_reset();
      test_modem_control();
      test_scratch_select();
      test_modem_status();
      test_fifo_flow();
      close_out();
   end
endmodule
